// ===== rtl/disk_status_return_encoder.sv
// primary status register and status return sequencing
`timescale 1ns/1ps
`include "status_defs.svh"
module disk_status_return_encoder
    import status_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = `READY_TIMEOUT_MS * `CLK_KHZ
)(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    // host register port
    input  wire logic [2:0]  register_select,
    input  wire logic        bus_read_direction,
    output logic      [7:0]  rd_data,
    // command execution side
    input  wire logic        cmd_start,
    input  wire logic [1:0]  cmd_class,
    input  wire logic [1:0]  cmd_drive,
    input  wire logic        cmd_done_ok,
    input  wire logic        fault_valid,
    input  wire fault_rep_t  fault_rep,
    input  wire logic        dma_partial,
    input  wire logic        dma_grant_late,
    output logic             dma_req_en,
    // drive and rate setup
    input  wire logic        drive_ready_pin,
    input  wire logic        track_zero_in,
    input  wire logic [3:0]  rates_defined,
    input  wire logic [7:0]  present_track_value,
    input  wire rate_set_t   rates_a,
    input  wire rate_set_t   rates_b,
    input  wire logic [7:0]  rate_alloc_map,
    output logic      [6:0]  sel_step_ms,
    output logic      [31:0] sel_step_cycles,
    // completion
    output logic             irq
);
    // ***********************************************************
    // input synchronisers
    // ***********************************************************
    logic [1:0] rdy_sync_q;
    logic [1:0] trk_sync_q;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdy_sync_q <= 2'h0;
            trk_sync_q <= 2'h0;
        end else begin
            rdy_sync_q <= {rdy_sync_q[0], drive_ready_pin};
            trk_sync_q <= {trk_sync_q[0], track_zero_in};
        end
    end
    wire drive_ready = rdy_sync_q[1];
    wire track_zero  = trk_sync_q[1];

    // ***********************************************************
    // rate selection per drive
    // ***********************************************************
    // map bit 2 selects drive 0, bit 1 drive 1 per the 06 example;
    // a set bit in drive 0's slot means A, a set bit in drive 1's slot means B
    wire        use_a    = rate_alloc_map[3'(2 - 32'(cmd_drive[0]))]
                           ^ cmd_drive[0];
    wire [7:0]  step_sel = use_a ? rates_a.step : rates_b.step;
    rate_decode u_rate (
        .rate_code   (step_sel),
        .rate_ms     (sel_step_ms),
        .rate_cycles (sel_step_cycles)
    );

    // ***********************************************************
    // ready timeout and local fault detection
    // ***********************************************************
    logic timed_out;
    ready_timer #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_timer (
        .ref_clk     (ref_clk),
        .arst_n      (arst_n),
        .wait_start  (cmd_start),
        .drive_ready (drive_ready),
        .timed_out   (timed_out)
    );
    logic to_seen_q;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) to_seen_q <= 1'b0;
        else         to_seen_q <= timed_out;
    end
    wire timeout_evt = timed_out & ~to_seen_q;

    // rates missing for the selected drive is caught at start
    wire no_rates = ~rates_defined[cmd_drive];
    // track zero must agree with stored track being zero
    wire trk_neq  = track_zero != (present_track_value == 8'h00);

    // ***********************************************************
    // code encoding
    // ***********************************************************
    logic [3:0] cond;
    always_comb begin
        cond = 4'h0;
        case (fault_rep.fault)
            F_NOT_READY:    cond = {`GRP_NOT_READY, fault_rep.drive};
            F_NO_RATES:     cond = {`GRP_NO_RATES, fault_rep.drive};
            F_TRK_MISS:     cond = {`GRP_TRK_MISS, fault_rep.drive};
            F_TRK_NEQ:      cond = {`GRP_TRK_NEQ, fault_rep.drive};
            F_SECT_NOT_FND: cond = `C_SECT_NOT_FND;
            F_ID_SYNC:      cond = `C_ID_SYNC;
            F_ID_MARK:      cond = `C_ID_MARK;
            F_ID_CRC:       cond = `C_ID_CRC;
            F_ID_BYTES:     cond = `C_ID_BYTES;
            F_DATA_SYNC:    cond = `C_DATA_SYNC;
            F_OVERFLOW:     cond = `C_OVER_UNDER_R;
            F_DATA_CRC:     cond = `C_DATA_CRC;
            F_WPROT:        cond = `C_WPROT;
            F_UNDERFLOW:    cond = (fault_rep.cls == `CLS_FORMAT)
                                   ? `C_UNDERFLOW_F
                                   : `C_UNDERFLOW_W;
            default:        cond = 4'h0;
        endcase
    end
    // format underflow lands in the write slot, since 1F is unused
    wire       fmt_underflow = fault_rep.fault == F_UNDERFLOW
                               && fault_rep.cls == `CLS_FORMAT;
    wire [5:0] ext_code      = fmt_underflow
                               ? {`CLS_WRITE, `C_UNDERFLOW_F}
                               : {fault_rep.cls, cond};

    // the ready timeout wins over external faults; class from the command
    logic       err_now;
    logic [5:0] err_code;
    always_comb begin
        err_now  = 1'b0;
        err_code = ext_code;
        if (timeout_evt) begin
            err_now  = 1'b1;
            err_code = {cmd_class, `GRP_NOT_READY, cmd_drive};
        end else if (fault_valid) begin
            err_now  = 1'b1;
            err_code = ext_code;
        end
    end

    // ***********************************************************
    // status sequencing
    // ***********************************************************
    phase_t     phase_q;
    logic [7:0] status_q;
    logic [5:0] code_q;
    logic       irq_q;
    logic       dma_en_q;
    wire        hs_abort = dma_partial | dma_grant_late;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_q  <= S_IDLE;
            status_q <= `ST_RESET_VAL;
            code_q   <= 6'h00;
            irq_q    <= 1'b0;
            dma_en_q <= 1'b0;
        end else begin
            irq_q <= 1'b0;
            case (phase_q)
                S_IDLE: begin
                    if (cmd_start) begin
                        status_q <= `ST_START;
                        dma_en_q <= 1'b1;
                        if (no_rates) begin
                            code_q  <= {cmd_class, `GRP_NO_RATES,
                                        cmd_drive};
                            phase_q <= S_ABORT;
                        end else begin
                            phase_q <= S_CODE;
                        end
                    end
                end
                S_CODE: begin
                    // here S_CODE means executing
                    if (hs_abort) begin
                        dma_en_q                <= 1'b0;
                        status_q[`ST_ABORT_BIT] <= 1'b0;
                    end
                    if (err_now) begin
                        status_q[`ST_ABORT_BIT] <= 1'b0;
                        code_q   <= err_code;
                        dma_en_q <= 1'b0;
                        phase_q  <= S_DONE;
                    end else if (cmd_done_ok && cmd_class == `CLS_RECAL
                                 && trk_neq) begin
                        status_q[`ST_ABORT_BIT] <= 1'b0;
                        dma_en_q <= 1'b0;
                        code_q  <= {`CLS_RECAL, `GRP_TRK_NEQ,
                                    cmd_drive};
                        phase_q <= S_DONE;
                    end else if (cmd_done_ok) begin
                        status_q <= `ST_IDLE_OK;
                        dma_en_q <= 1'b0;
                        irq_q    <= 1'b1;
                        phase_q  <= S_IDLE;
                    end
                end
                S_ABORT: begin
                    status_q[`ST_ABORT_BIT] <= 1'b0;
                    dma_en_q <= 1'b0;
                    phase_q  <= S_DONE;
                end
                S_DONE: begin
                    // code lands one edge before idle goes high
                    status_q[5:0] <= code_q;
                    phase_q       <= S_IDLE;
                    irq_q         <= 1'b1;
                end
                default: phase_q <= S_IDLE;
            endcase
            // every code, 3F included, must end with the idle bit high
            if (phase_q == S_IDLE && !cmd_start
                && status_q[`ST_IDLE_BIT] == 1'b0) begin
                status_q[`ST_IDLE_BIT] <= 1'b1;
            end
        end
    end

    // ***********************************************************
    // host read port
    // ***********************************************************
    wire status_sel = bus_read_direction
                      && register_select == `SEL_STATUS;
    assign rd_data    = status_sel ? status_q : 8'h00;
    assign dma_req_en = dma_en_q;
    assign irq        = irq_q;
endmodule : disk_status_return_encoder

// ===== rtl/status_defs.svh
// constants for the disk status return encoder
`ifndef STATUS_DEFS_SVH
`define STATUS_DEFS_SVH
// status register values
`define ST_IDLE_OK      8'hFF
`define ST_START        8'h7F
`define ST_RESET_VAL    8'hFF
// bit positions (bit 7 is the busy/idle bit, bit 6 the abort bit)
`define ST_IDLE_BIT     7
`define ST_ABORT_BIT    6
// register select for the primary status register
`define SEL_STATUS      3'h0
// command classes (top two code bits)
`define CLS_RECAL       2'h0
`define CLS_FORMAT      2'h1
`define CLS_READ        2'h2
`define CLS_WRITE       2'h3
// condition groups in the low four code bits
`define GRP_NOT_READY   2'h0
`define GRP_NO_RATES    2'h1
`define GRP_TRK_MISS    2'h2
`define GRP_TRK_NEQ     2'h3
// fixed condition codes
`define C_SECT_NOT_FND  4'h8
`define C_ID_SYNC       4'h9
`define C_ID_MARK       4'hA
`define C_ID_CRC        4'hB
`define C_ID_BYTES      4'hC
`define C_WPROT         4'hD
`define C_DATA_SYNC     4'hD
`define C_OVER_UNDER_R  4'hE
`define C_DATA_CRC      4'hF
`define C_UNDERFLOW_W   4'hE
`define C_UNDERFLOW_F   4'hF
// drive ready timeout
`define READY_TIMEOUT_MS 1250
`define CLK_KHZ          25000
// rate encoding: twice the milliseconds plus one
`define RATE_MS_SHIFT    1
`endif

// ===== rtl/status_pkg.sv
// types shared by the disk status return encoder
package status_pkg;
    typedef enum logic [3:0] {
        F_NONE, F_NOT_READY, F_NO_RATES, F_TRK_MISS, F_TRK_NEQ,
        F_SECT_NOT_FND, F_ID_SYNC, F_ID_MARK, F_ID_CRC, F_ID_BYTES,
        F_DATA_SYNC, F_OVERFLOW, F_DATA_CRC, F_WPROT, F_UNDERFLOW
    } fault_t;

    typedef struct packed {
        logic [1:0] cls;
        logic [1:0] drive;
        fault_t     fault;
    } fault_rep_t;

    typedef struct packed {
        logic [7:0] step;
        logic [7:0] settle;
        logic [7:0] load;
    } rate_set_t;

    typedef enum logic [1:0] { S_IDLE, S_ABORT, S_CODE, S_DONE } phase_t;
endpackage : status_pkg

// ===== rtl/rate_decode.sv
// decodes one encoded rate byte into milliseconds and clock cycles
`timescale 1ns/1ps
`include "status_defs.svh"
module rate_decode
    import status_pkg::*;
(
    // encoded value from the host
    input  wire logic [7:0]  rate_code,
    // decoded time
    output logic      [6:0]  rate_ms,
    output logic      [31:0] rate_cycles
);
    // stored code is 2*ms+1, so the ms value is the upper seven bits
    assign rate_ms     = rate_code[7:`RATE_MS_SHIFT];
    assign rate_cycles = 32'(rate_ms) * 32'(`CLK_KHZ);
endmodule : rate_decode

// ===== rtl/ready_timer.sv
// counts the wait for drive ready and flags the timeout
`timescale 1ns/1ps
`include "status_defs.svh"
module ready_timer
    import status_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = `READY_TIMEOUT_MS * `CLK_KHZ
)(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic arst_n,
    // control
    input  wire logic wait_start,
    input  wire logic drive_ready,
    // result
    output logic      timed_out
);
    logic [31:0] cnt_q;
    logic        run_q;
    logic        to_q;

    // counter stops on ready; a new start rearms it
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 32'h0000_0000;
            run_q <= 1'b0;
            to_q  <= 1'b0;
        end else if (wait_start) begin
            cnt_q <= 32'h0000_0000;
            run_q <= 1'b1;
            to_q  <= 1'b0;
        end else if (run_q && drive_ready) begin
            run_q <= 1'b0;
        end else if (run_q && cnt_q == TIMEOUT_CYCLES - 1) begin
            run_q <= 1'b0;
            to_q  <= 1'b1;
        end else if (run_q) begin
            cnt_q <= cnt_q + 32'h0000_0001;
        end
    end
    assign timed_out = to_q;
endmodule : ready_timer

// ===== testbench/disk_status_return_encoder_asserts.sv
// assertion checker for the disk status return encoder
`timescale 1ns/1ps
module disk_status_return_encoder_asserts
    import status_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = 100
)(
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       arst_n,
    // host side
    input wire logic [2:0] register_select,
    input wire logic       bus_read_direction,
    input wire logic [7:0] rd_data,
    // execution side
    input wire logic       cmd_start,
    input wire logic       cmd_done_ok,
    input wire logic       fault_valid,
    input wire fault_rep_t fault_rep,
    input wire logic       dma_partial,
    input wire logic       dma_grant_late,
    input wire logic       dma_req_en,
    input wire logic       irq,
    // track state for the recal check
    input wire logic [1:0] cmd_class,
    input wire logic       track_zero_in,
    input wire logic [7:0] present_track_value
);
    // status is only seen at select 000 with read direction
    wire logic vis  = (register_select == 3'h0) && bus_read_direction;
    wire logic busy = vis && !rd_data[7];
    wire logic flt  = fault_valid && busy;
    // a format underflow reports in the write class slot
    wire logic [1:0] exp_cls = (fault_rep.fault == F_UNDERFLOW
                                && fault_rep.cls == 2'h1)
                               ? 2'h3 : fault_rep.cls;
    // recal whose track zero disagrees with the stored track
    wire logic trk_bad = cmd_class == 2'h0
                         && track_zero_in != (present_track_value == 8'h00);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    AST_START_LOAD: assert property (
        cmd_start && vis && rd_data[7] ##1 vis |-> rd_data == 8'h7F)
        else $error("status not 7F after start");
    AST_DONE_FF: assert property (
        cmd_done_ok && busy && !trk_bad ##1 vis
        |-> rd_data == 8'hFF && irq)
        else $error("success did not give FF with irq");
    AST_RECAL_NEQ: assert property (
        cmd_done_ok && busy && trk_bad ##1 vis
        |-> !rd_data[6] ##1 irq && rd_data[5:2] == 4'h3 ##1 rd_data[7])
        else $error("recal track mismatch not reported");
    AST_ERR_ABORT: assert property (
        flt ##1 vis |-> rd_data[7:6] == 2'b00)
        else $error("abort bit not first on error");
    AST_ERR_CODE: assert property (
        flt ##2 vis
        |-> !rd_data[7] && irq && rd_data[5:4] == $past(exp_cls, 2))
        else $error("code not loaded before idle");
    AST_ERR_IDLE: assert property (
        flt ##3 vis |-> rd_data[7] && $stable(rd_data[5:0]))
        else $error("idle bit late or code moved");
    AST_DMA_ABORT: assert property (
        (dma_partial || dma_grant_late) && busy ##1 vis
        |-> !rd_data[6] && !dma_req_en)
        else $error("handshake abort not flagged");
    AST_SEL_OFF: assert property (
        !vis |-> rd_data == 8'h00)
        else $error("status seen off its select");
    AST_IRQ_PULSE: assert property (
        irq |=> !irq)
        else $error("irq longer than one cycle");
    AST_HOLD: assert property (
        vis && rd_data[7] && !cmd_start ##1 vis |-> $stable(rd_data))
        else $error("idle status changed without start");

    cover property (flt);
    cover property (cmd_done_ok && busy);
    cover property (dma_partial && busy);
    cover property (cmd_done_ok && busy && trk_bad);
endmodule : disk_status_return_encoder_asserts

// ===== testbench/host_model.sv
// host side model that selects the register to read
`timescale 1ns/1ps
module host_model (
    // clock
    input wire logic  ref_clk,
    // register access
    output logic [2:0] register_select,
    output logic       bus_read_direction
);
    // default to reading the primary status register
    initial begin
        register_select    = 3'h0;
        bus_read_direction = 1'b1;
    end
    // change select after an edge and hold it a full cycle
    task automatic select_reg(input logic [2:0] sel, input logic rd);
        @(posedge ref_clk);
        register_select    <= sel;
        bus_read_direction <= rd;
        @(posedge ref_clk);
        #1;
    endtask : select_reg
endmodule : host_model

// ===== testbench/disk_status_return_encoder_test.sv
// self-checking bench for the disk status return encoder
`timescale 1ns/1ps
module disk_status_return_encoder_test;
    import status_pkg::*;
    localparam int unsigned TMO = 100; // short ready wait keeps runs brief
    logic ref_clk, arst_n, bus_read_direction, irq, dma_req_en;
    logic cmd_start, cmd_done_ok, fault_valid, dma_partial, dma_grant_late;
    logic drive_ready_pin, track_zero_in;
    logic [1:0] cmd_class, cmd_drive;
    logic [2:0] register_select;
    logic [3:0] rates_defined;
    logic [6:0] sel_step_ms;
    logic [7:0] rd_data, present_track_value, rate_alloc_map;
    logic [31:0] sel_step_cycles;
    fault_rep_t fault_rep;
    rate_set_t rates_a, rates_b;
    int failures, check_count, cycles;
    fault_t ftab [17] = '{F_TRK_MISS, F_TRK_NEQ, F_SECT_NOT_FND, F_WPROT,
        F_UNDERFLOW, F_SECT_NOT_FND, F_ID_SYNC, F_ID_MARK, F_ID_CRC,
        F_ID_BYTES, F_DATA_SYNC, F_OVERFLOW, F_DATA_CRC, F_SECT_NOT_FND,
        F_ID_BYTES, F_WPROT, F_UNDERFLOW};
    logic [1:0] fcls [17] = '{0, 0, 1, 1, 1, 2, 2, 2, 2, 2, 2, 2, 2, 3, 3, 3, 3};
    logic [5:0] fcode [17] = '{6'h08, 6'h0D, 6'h18, 6'h1D, 6'h3F, 6'h28,
        6'h29, 6'h2A, 6'h2B, 6'h2C, 6'h2D, 6'h2E, 6'h2F, 6'h38, 6'h3C,
        6'h3D, 6'h3E};

    disk_status_return_encoder #(.TIMEOUT_CYCLES(TMO)) i_dut (
        .ref_clk, .arst_n, .register_select, .bus_read_direction, .rd_data,
        .cmd_start, .cmd_class, .cmd_drive, .cmd_done_ok, .fault_valid,
        .fault_rep, .dma_partial, .dma_grant_late, .dma_req_en,
        .drive_ready_pin, .track_zero_in, .rates_defined,
        .present_track_value, .rates_a, .rates_b, .rate_alloc_map,
        .sel_step_ms, .sel_step_cycles, .irq);
    host_model i_host (.ref_clk, .register_select, .bus_read_direction);

    // ****************************************
    // clock, watchdog and helpers
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // a hang counts as a mismatch instead of running forever
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            test_done();
        end
    end
    task automatic test_done;
        if (failures == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic start(input logic [1:0] cls, input logic [1:0] drv);
        @(posedge ref_clk);
        cmd_class <= cls;
        cmd_drive <= drv;
        cmd_start <= 1'b1;
        @(posedge ref_clk);
        cmd_start <= 1'b0;
        #1;
    endtask : start
    task automatic raise(input fault_t f, input logic [1:0] cls);
        @(posedge ref_clk);
        fault_rep   <= '{cls, cmd_drive, f};
        fault_valid <= 1'b1;
        @(posedge ref_clk);
        fault_valid <= 1'b0;
        #1;
    endtask : raise
    // bounded wait, long enough for the shortened ready timeout
    task automatic wait_idle;
        for (int i = 0; i < 400 && rd_data[7] !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
    endtask : wait_idle

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {cmd_start, cmd_done_ok, fault_valid, dma_partial} = '0;
        {dma_grant_late, cmd_class, cmd_drive, fault_rep} = '0;
        {drive_ready_pin, track_zero_in, present_track_value} = {2'b11, 8'h00};
        rates_defined  = 4'hF;
        rates_a        = '{8'h15, 8'h11, 8'h47};
        rates_b        = '{8'h29, 8'h19, 8'h65};
        rate_alloc_map = 8'h06;
        arst_n         = 1'b0;
        repeat (25) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        #1;
        check("reset status", 8'hFF, rd_data);
        // rate set per drive, then clean recalibration
        for (int d = 0; d < 2; d++) begin
            start(2'h0, d[1:0]);
            check("start status", 8'h7F, rd_data);
            check("step ms", d ? 7'd20 : 7'd10, sel_step_ms);
            check("step cyc", d ? 500000 : 250000, sel_step_cycles);
            @(posedge ref_clk) cmd_done_ok <= 1'b1;
            @(posedge ref_clk) cmd_done_ok <= 1'b0;
            #1;
            check("done irq", 1'b1, irq);
            check("done status", 8'hFF, rd_data);
        end
        // recal ends with track zero disagreeing with the stored track
        @(posedge ref_clk) present_track_value <= 8'h05;
        start(2'h0, 2'h2);
        @(posedge ref_clk) cmd_done_ok <= 1'b1;
        @(posedge ref_clk) cmd_done_ok <= 1'b0;
        wait_idle();
        check("track neq", 8'h8E, rd_data);
        @(posedge ref_clk) present_track_value <= 8'h00;
        // every listed fault code of every class
        for (int i = 0; i < 17; i++) begin
            start(fcls[i], 2'(i));
            raise(ftab[i], fcls[i]);
            wait_idle();
            check("error status", {2'b10, fcode[i]}, rd_data);
        end
        // drive never ready: the ready wait runs out
        @(posedge ref_clk) drive_ready_pin <= 1'b0;
        start(2'h2, 2'h3);
        wait_idle();
        check("not ready", 8'hA3, rd_data);
        @(posedge ref_clk) drive_ready_pin <= 1'b1;
        // drive 1 never had rates defined, in every class
        @(posedge ref_clk) rates_defined <= 4'b1101;
        for (int c = 0; c < 4; c++) begin
            start(c[1:0], 2'h1);
            wait_idle();
            check("no rates", {2'b10, c[1:0], 4'h5}, rd_data);
        end
        @(posedge ref_clk) rates_defined <= 4'hF;
        // partial transfer on a read, late grant on a write
        for (int k = 0; k < 2; k++) begin
            start(k ? 2'h3 : 2'h2, 2'h0);
            @(posedge ref_clk) {dma_grant_late, dma_partial} <= k ? 2'b10 : 2'b01;
            @(posedge ref_clk) {dma_grant_late, dma_partial} <= 2'b00;
            #1;
            check("abort flag", 2'b00, rd_data[7:6]);
            check("request stop", 1'b0, dma_req_en);
            raise(k ? F_UNDERFLOW : F_OVERFLOW, k ? 2'h3 : 2'h2);
            wait_idle();
            check("abort end", k ? 8'hBE : 8'hAE, rd_data);
        end
        // status is hidden at other selects and on writes
        i_host.select_reg(3'h1, 1'b1);
        check("other select", 8'h00, rd_data);
        i_host.select_reg(3'h0, 1'b0);
        check("write dir", 8'h00, rd_data);
        i_host.select_reg(3'h0, 1'b1);
        check("status kept", 8'hBE, rd_data);
        test_done();
    end
endmodule : disk_status_return_encoder_test

bind disk_status_return_encoder disk_status_return_encoder_asserts #(
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) i_asserts (
    .ref_clk, .arst_n, .register_select, .bus_read_direction, .rd_data,
    .cmd_start, .cmd_done_ok, .fault_valid, .fault_rep, .dma_partial,
    .dma_grant_late, .dma_req_en, .irq, .cmd_class, .track_zero_in,
    .present_track_value);
